// file: verilog/dacus_pkg.sv
/*
 * Shared constants for the two-channel DAC update scheduler.
 * Assumes an 8-bit special-function register bus with one-cycle strobes.
 */
package dacus_pkg;
    localparam logic [7:0] CTRL0_ADDR = 8'hd4;
    localparam logic [7:0] LOW0_ADDR = 8'hd2;
    localparam logic [7:0] HIGH0_ADDR = 8'hd3;
    localparam logic [7:0] CTRL1_ADDR = 8'hd7;
    localparam logic [7:0] LOW1_ADDR = 8'hd5;
    localparam logic [7:0] HIGH1_ADDR = 8'hd6;
    localparam int ENABLE_BIT = 7;
    localparam int SOURCE_LSB = 3;
    localparam int FORMAT_LSB = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [11:0] CODE_RESET = 12'h000;
    localparam logic [7:0] CTRL_WMASK = 8'h9f;

    typedef enum logic [1:0] {
        DACUS_SRC_WRITE = 2'b00,
        DACUS_SRC_TMR3 = 2'b01,
        DACUS_SRC_TMR4 = 2'b10,
        DACUS_SRC_TMR2 = 2'b11
    } dacus_src_t;

    typedef enum logic [2:0] {
        DACUS_FMT_4_8 = 3'b000,
        DACUS_FMT_5_7 = 3'b001,
        DACUS_FMT_6_6 = 3'b010,
        DACUS_FMT_7_5 = 3'b011,
        DACUS_FMT_8_4 = 3'b100
    } dacus_fmt_t;
endpackage : dacus_pkg

// file: verilog/dacus_scheduler.sv
/*
 * Two identical DAC channels: control, data bytes and update scheduling.
 * Assumes register strobes and timer overflow pulses are one clk cycle wide.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1: Each channel's latch holds a 12-bit unsigned code, 000 to fff.
// R2: Disabled channel drives output enable inactive and asserts shutdown.
// R3: Update source 00 (default) latches data on each high-byte write.
// R4: In on-demand mode low-byte writes are stored without changing output.
// R5: Software writes low byte before high byte for full resolution.
// R6: For 8-bit use, software preloads low byte then writes high only.
// R7: Sources 01, 10, 11 wait for timer 3, 4 or 2 overflow.
// R8: On the chosen overflow both bytes are copied to the latch at once.
// R9: Control bit 7 enables the channel; clear means shutdown.
// R10: Control bits 6 and 5 read zero and ignore writes.
// R11: Control bits 2 to 0 select the data word placement.
// R12: Format 000: high[3:0] and whole low byte.
// R13: Format 001: high[4:0] and low[7:1].
// R14: Format 010: high[5:0] and low[7:2].
// R15: Format 011: high[6:0] and low[7:3].
// R16: Software sets the bias generator before using any channel.
// R17: The second channel behaves identically with its own registers.
// R18: Format 100: high[7:0] and low[7:4]; 101 to 111 reserved.
// R19: Data writes while a timer update waits overwrite; latest transfers.
module dacus_scheduler (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic timer2Overflow,
    input wire logic timer3Overflow,
    input wire logic timer4Overflow,
    output logic [11:0] codeOut0,
    output logic [11:0] codeOut1,
    output logic outputEnable0_n,
    output logic outputEnable1_n,
    output logic shutdown0,
    output logic shutdown1
);
    typedef struct packed {
        logic [1:0][7:0] ctrl;
        logic [1:0][7:0] low;
        logic [1:0][7:0] high;
        logic [1:0][11:0] code;
        logic [7:0] rdata;
    } dacus_state_t;

    dacus_state_t st_r;
    dacus_state_t st_nxt;
    logic [1:0] ctrlHit;
    logic [1:0] lowHit;
    logic [1:0] highHit;

    function automatic logic [11:0] dacusFormat(input logic [2:0] fmt,
                                                input logic [7:0] hi,
                                                input logic [7:0] lo);
        logic [11:0] word;
        word = {hi[3:0], lo};
        case (fmt)
            dacus_pkg::DACUS_FMT_4_8: word = {hi[3:0], lo}; // R12
            dacus_pkg::DACUS_FMT_5_7: word = {hi[4:0], lo[7:1]}; // R13
            dacus_pkg::DACUS_FMT_6_6: word = {hi[5:0], lo[7:2]}; // R14
            dacus_pkg::DACUS_FMT_7_5: word = {hi[6:0], lo[7:3]}; // R15
            dacus_pkg::DACUS_FMT_8_4: word = {hi, lo[7:4]}; // R18
            default: word = {hi, lo[7:4]}; // R18
        endcase
        return word; // R1 R11
    endfunction : dacusFormat

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.
    always_comb begin
        ctrlHit = 2'b00;
        lowHit = 2'b00;
        highHit = 2'b00;
        if (regAddr == dacus_pkg::CTRL0_ADDR) begin
            ctrlHit[0] = 1'b1;
        end else if (regAddr == dacus_pkg::LOW0_ADDR) begin
            lowHit[0] = 1'b1;
        end else if (regAddr == dacus_pkg::HIGH0_ADDR) begin
            highHit[0] = 1'b1;
        end else if (regAddr == dacus_pkg::CTRL1_ADDR) begin
            ctrlHit[1] = 1'b1;
        end else if (regAddr == dacus_pkg::LOW1_ADDR) begin
            lowHit[1] = 1'b1;
        end else if (regAddr == dacus_pkg::HIGH1_ADDR) begin
            highHit[1] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state for both channels.
    always_comb begin
        logic [7:0] lo;
        logic [7:0] hi;
        logic [1:0] src;
        logic tick;
        lo = 8'h00;
        hi = 8'h00;
        src = 2'b00;
        tick = 1'b0;
        st_nxt = st_r;
        for (int ch = 0; ch < 2; ch++) begin // R17
            if (regWrite && ctrlHit[ch]) begin
                st_nxt.ctrl[ch] = regWdata & dacus_pkg::CTRL_WMASK; // R9 R10 R11
            end
            if (regWrite && lowHit[ch]) begin
                st_nxt.low[ch] = regWdata; // R4 R19
            end
            if (regWrite && highHit[ch]) begin
                st_nxt.high[ch] = regWdata; // R19
            end
            lo = st_nxt.low[ch];
            hi = st_nxt.high[ch];
            src = st_r.ctrl[ch][dacus_pkg::SOURCE_LSB +: 2];
            case (src)
                dacus_pkg::DACUS_SRC_WRITE: tick = regWrite && highHit[ch]; // R3
                dacus_pkg::DACUS_SRC_TMR3: tick = timer3Overflow; // R7
                dacus_pkg::DACUS_SRC_TMR4: tick = timer4Overflow; // R7
                default: tick = timer2Overflow; // R7
            endcase
            if (tick) begin
                st_nxt.code[ch] = dacusFormat(
                    st_r.ctrl[ch][dacus_pkg::FORMAT_LSB +: 3], hi, lo); // R8
            end
        end
        st_nxt.rdata = 8'h00;
        for (int ch = 0; ch < 2; ch++) begin
            if (ctrlHit[ch]) begin
                st_nxt.rdata = st_r.ctrl[ch]; // R10
            end else if (lowHit[ch]) begin
                st_nxt.rdata = st_r.low[ch];
            end else if (highHit[ch]) begin
                st_nxt.rdata = st_r.high[ch];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r.ctrl <= {2{dacus_pkg::CTRL_RESET}};
            st_r.low <= {2{dacus_pkg::DATA_RESET}};
            st_r.high <= {2{dacus_pkg::DATA_RESET}};
            st_r.code <= {2{dacus_pkg::CODE_RESET}};
            st_r.rdata <= dacus_pkg::DATA_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign regRdata = st_r.rdata;
    assign codeOut0 = st_r.code[0];
    assign codeOut1 = st_r.code[1];
    assign outputEnable0_n = ~st_r.ctrl[0][dacus_pkg::ENABLE_BIT]; // R2
    assign outputEnable1_n = ~st_r.ctrl[1][dacus_pkg::ENABLE_BIT]; // R2
    assign shutdown0 = ~st_r.ctrl[0][dacus_pkg::ENABLE_BIT]; // R2
    assign shutdown1 = ~st_r.ctrl[1][dacus_pkg::ENABLE_BIT]; // R2

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    sequence highWrite0;
        regWrite && highHit[0] && st_r.ctrl[0][4:3] == 2'b00;
    endsequence

    a_ondemand_update: assert property (@(posedge clk) disable iff (!reset_n) // R3
        highWrite0 and (st_r.ctrl[0][2:0] == 3'b000)
        |=> codeOut0 == {$past(regWdata[3:0]), st_r.low[0]})
        else $error("high-byte write did not update channel 0");
    a_low_held: assert property (@(posedge clk) disable iff (!reset_n) // R4
        regWrite && lowHit[0] && !timer2Overflow && !timer3Overflow && !timer4Overflow
        |=> $stable(codeOut0))
        else $error("low-byte write changed channel 0 output");
    a_timer3_wait: assert property (@(posedge clk) disable iff (!reset_n) // R7
        st_r.ctrl[0][4:3] == 2'b01 && !timer3Overflow |=> $stable(codeOut0))
        else $error("channel 0 updated without timer 3 overflow");
    a_timer_copy: assert property (@(posedge clk) disable iff (!reset_n) // R8
        st_r.ctrl[1][4:3] == 2'b11 && timer2Overflow && !regWrite
        && st_r.ctrl[1][2:0] == 3'b000
        |=> codeOut1 == {$past(st_r.high[1][3:0]), $past(st_r.low[1])})
        else $error("timer 2 overflow did not copy channel 1 data");
    a_disable_off: assert property (@(posedge clk) disable iff (!reset_n) // R2
        regWrite && ctrlHit[0] && !regWdata[7] |=> outputEnable0_n && shutdown0)
        else $error("disabled channel 0 not in shutdown");
    a_enable_bit: assert property (@(posedge clk) disable iff (!reset_n) // R9
        regWrite && ctrlHit[1] |=> shutdown1 == !$past(regWdata[7]))
        else $error("enable bit write not applied to channel 1");
    a_unused_zero: assert property (@(posedge clk) disable iff (!reset_n) // R10
        ctrlHit[0] |=> regRdata[6:5] == 2'b00)
        else $error("unused control bits read nonzero");
    a_format_five: assert property (@(posedge clk) disable iff (!reset_n) // R13
        highWrite0 and (st_r.ctrl[0][2:0] == 3'b001)
        |=> codeOut0 == {$past(regWdata[4:0]), st_r.low[0][7:1]})
        else $error("format 001 placement wrong");
    a_format_six: assert property (@(posedge clk) disable iff (!reset_n) // R14
        highWrite0 and (st_r.ctrl[0][2:0] == 3'b010)
        |=> codeOut0 == {$past(regWdata[5:0]), st_r.low[0][7:2]})
        else $error("format 010 placement wrong");
    a_format_seven: assert property (@(posedge clk) disable iff (!reset_n) // R15
        highWrite0 and (st_r.ctrl[0][2:0] == 3'b011)
        |=> codeOut0 == {$past(regWdata[6:0]), st_r.low[0][7:3]})
        else $error("format 011 placement wrong");
    a_format_eight: assert property (@(posedge clk) disable iff (!reset_n) // R18
        highWrite0 and (st_r.ctrl[0][2:0] >= 3'b100)
        |=> codeOut0 == {$past(regWdata), st_r.low[0][7:4]})
        else $error("format 100 or reserved placement wrong");

    // A timer-scheduled update: the selected overflow with no write in flight.
    sequence timer3Tick0;
        st_r.ctrl[0][4:3] == 2'b01 && timer3Overflow && !regWrite;
    endsequence

    a_timer3_copy: assert property (@(posedge clk) disable iff (!reset_n) // R8
        timer3Tick0 and (st_r.ctrl[0][2:0] == 3'b000)
        |=> codeOut0 == {$past(st_r.high[0][3:0]), $past(st_r.low[0])})
        else $error("timer 3 overflow did not copy channel 0 data");
    a_timer4_wait: assert property (@(posedge clk) disable iff (!reset_n) // R7
        st_r.ctrl[0][4:3] == 2'b10 && !timer4Overflow |=> $stable(codeOut0))
        else $error("channel 0 updated without timer 4 overflow");
    a_timer2_wait: assert property (@(posedge clk) disable iff (!reset_n) // R7 R17
        st_r.ctrl[1][4:3] == 2'b11 && !timer2Overflow |=> $stable(codeOut1))
        else $error("channel 1 updated without timer 2 overflow");
    a_enable_on: assert property (@(posedge clk) disable iff (!reset_n) // R9
        regWrite && ctrlHit[0] && regWdata[7] |=> !outputEnable0_n && !shutdown0)
        else $error("enabled channel 0 still in shutdown");
endmodule : dacus_scheduler

// file: bench/test_dacus_scheduler.sv
/*
 * Self-checking bench for the two-channel DAC update scheduler.
 * Assumes the design of dacus_scheduler.sv and dacus_pkg.sv is compiled first.
 */
`timescale 1ns/1ps
module test_dacus_scheduler;
    logic clk, reset_n, regWrite, timer2Overflow, timer3Overflow, timer4Overflow;
    logic [7:0] regAddr, regWdata, regRdata, rv;
    logic [11:0] codeOut0, codeOut1;
    logic outputEnable0_n, outputEnable1_n, shutdown0, shutdown1;
    int n_mismatch = 0;
    int n_tests = 0;

    dacus_scheduler i_dut(.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
        .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
        .timer2Overflow(timer2Overflow), .timer3Overflow(timer3Overflow),
        .timer4Overflow(timer4Overflow), .codeOut0(codeOut0), .codeOut1(codeOut1),
        .outputEnable0_n(outputEnable0_n), .outputEnable1_n(outputEnable1_n),
        .shutdown0(shutdown0), .shutdown1(shutdown1));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Register kind: 0 low byte, 1 high byte, 2 control.
    function automatic logic [7:0] adr(input int ch, input int k);
        case (k)
            0: return ch ? dacus_pkg::LOW1_ADDR : dacus_pkg::LOW0_ADDR;
            1: return ch ? dacus_pkg::HIGH1_ADDR : dacus_pkg::HIGH0_ADDR;
            default: return ch ? dacus_pkg::CTRL1_ADDR : dacus_pkg::CTRL0_ADDR;
        endcase
    endfunction : adr

    function automatic logic [11:0] code(input int ch);
        return ch ? codeOut1 : codeOut0;
    endfunction : code

    function automatic logic [11:0] pins(input int ch);
        return ch ? {10'h000, outputEnable1_n, shutdown1} : {10'h000, outputEnable0_n, shutdown0};
    endfunction : pins

    function automatic logic [11:0] place(input int f, input logic [7:0] h, input logic [7:0] l);
        case (f)
            0: return {h[3:0], l};
            1: return {h[4:0], l[7:1]};
            2: return {h[5:0], l[7:2]};
            3: return {h[6:0], l[7:3]};
            default: return {h, l[7:4]};
        endcase
    endfunction : place

    task automatic wr(input int ch, input int k, input logic [7:0] d);
        @(posedge clk);
        regAddr <= adr(ch, k);
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input int ch, input int k);
        @(posedge clk);
        regAddr <= adr(ch, k);
        @(posedge clk);
        #1;
        rv = regRdata;
    endtask : rd

    // Timer codes 2, 3 and 4 select the matching overflow pulse.
    task automatic pulse(input int t);
        @(posedge clk);
        timer2Overflow <= (t == 2);
        timer3Overflow <= (t == 3);
        timer4Overflow <= (t == 4);
        @(posedge clk);
        {timer2Overflow, timer3Overflow, timer4Overflow} <= 3'h0;
        #1;
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset(input int ch);
        rd(ch, 2);
        chk("ctrl reset", 12'h000, {4'h0, rv});
        chk("code reset", 12'h000, code(ch));
        chk("pins reset", 12'h003, pins(ch));
    endtask : t_reset

    task automatic t_ctrl(input int ch);
        wr(ch, 2, 8'hff);
        rd(ch, 2);
        chk("ctrl readback", 12'h09f, {4'h0, rv});
        chk("pins enabled", 12'h000, pins(ch));
        wr(ch, 2, 8'h00);
        chk("pins disabled", 12'h003, pins(ch));
    endtask : t_ctrl

    task automatic t_demand(input int ch);
        wr(ch, 2, 8'h80);
        wr(ch, 0, 8'hff);
        wr(ch, 1, 8'hff);
        chk("full scale", 12'hfff, code(ch));
        wr(ch, 0, 8'h00);
        chk("low held", 12'hfff, code(ch));
        wr(ch, 1, 8'h00);
        chk("zero scale", 12'h000, code(ch));
        wr(ch, 2, 8'h84);
        wr(ch, 1, 8'hab);
        chk("eight bit", place(4, 8'hab, 8'h00), code(ch));
    endtask : t_demand

    task automatic t_format(input int ch);
        for (int f = 0; f < 8; f++) begin
            wr(ch, 2, 8'h80 | 8'(f));
            wr(ch, 0, 8'hc3);
            wr(ch, 1, 8'ha5);
            chk("placement", place(f, 8'ha5, 8'hc3), code(ch));
        end
    endtask : t_format

    task automatic t_timer(input int ch);
        int tm [3] = '{3, 4, 2};
        for (int s = 1; s < 4; s++) begin
            wr(ch, 2, 8'h80);
            wr(ch, 0, 8'hc3);
            wr(ch, 1, 8'h00);
            wr(ch, 2, 8'h80 | 8'(s << 3));
            wr(ch, 0, 8'h11);
            wr(ch, 1, 8'(s));
            chk("held write", place(0, 8'h00, 8'hc3), code(ch));
            pulse(tm[s % 3]);
            pulse(tm[(s + 1) % 3]);
            chk("other timer", place(0, 8'h00, 8'hc3), code(ch));
            wr(ch, 0, 8'h5a);
            pulse(tm[s - 1]);
            chk("timer update", {4'(s), 8'h5a}, code(ch));
        end
    endtask : t_timer

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out

    initial begin
        {reset_n, regWrite, timer2Overflow, timer3Overflow, timer4Overflow} = 5'h00;
        regAddr = 8'h00;
        regWdata = 8'h00;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        // Each channel runs the same checks on its own registers.
        for (int ch = 0; ch < 2; ch++) begin
            t_reset(ch);
            $display("reset test done on channel %0d", ch);
            t_ctrl(ch);
            $display("control test done on channel %0d", ch);
            t_demand(ch);
            $display("on-demand test done on channel %0d", ch);
            t_format(ch);
            $display("format test done on channel %0d", ch);
            t_timer(ch);
            $display("timer test done on channel %0d", ch);
        end
        close_out();
    end
endmodule : test_dacus_scheduler
